/* File: rtl/cbl_config_loader.sv */
// configuration byte loader: non-volatile bytes, reset reload and AXI4-Lite access
//
// Contract
// - after reset, each configured field is copied into its run-time control bit
// - software reset reloads all fields except the boot-select bit
// - unprogrammed configuration bytes read as all ones
// - boot-source bit 1 boots application memory, 0 boots loader memory
// - second byte is data-flash base high byte, used only when enable_n is 0
// - base high byte zero means no application memory, minimal program region
// - brown-out detect bit 1 enables detection, 0 disables
// - brown-out level bit 1 lower threshold, 0 higher threshold
// - brown-out reset bit 1 lets brown-out reset the chip
// - watchdog bit active low; run-time enable loads its inverse
// - clock filter bit 1 enables the input clock noise filter
// - rc frequency bit 1 bypasses divide-by-two, 0 selects half frequency; rc_frequency_select is forced to 0 unless clock source is internal rc
// - clock source bits: 11 internal rc, 10 external input, 0x crystal
// - non-software resets load boot-select with inverted boot-source bit
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module cbl_config_loader
  import cbl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic chip_reset_n,
  output logic runtime_boot_select,
  output logic watchdog_run_enable,
  output logic brownout_detect_enable,
  output logic brownout_level_low,
  output logic brownout_reset_enable,
  output logic [7:0] data_flash_base_high,
  output logic data_flash_active,
  output logic application_memory_present,
  output logic clock_filter_enable,
  output logic rc_frequency_select,
  output logic [1:0] clock_source_sel
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CBL_ST_RUN,
    CBL_ST_HOLD_FULL,
    CBL_ST_HOLD_SOFT
  } cbl_state_t;

  typedef struct packed {
    cbl_state_t st;
    logic [3:0] hold_cnt;
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic boot_sel;
    logic wdog_en;
    logic bo_det;
    logic bo_lvl;
    logic bo_rst;
    logic [7:0] df_base;
    logic df_act;
    logic app_mem;
    logic clk_filt;
    logic rc_full;
    logic [1:0] clk_src;
    logic last_soft;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cbl_regs_t;

  cbl_regs_t r_q;
  cbl_regs_t r_d;

  logic dec_boot;
  logic dec_wdog;
  logic dec_bo_det;
  logic dec_bo_lvl;
  logic dec_bo_rst;
  logic dec_df_act;
  logic [7:0] dec_df_base;
  logic dec_app_mem;
  logic dec_clk_filt;
  logic dec_rc_full;
  cbl_clk_src_t dec_clk_src;

  // decode always looks at the stored bytes so a reload is one cycle deep
  cbl_field_decode u_decode (
    .cfg0(r_q.cfg0),
    .cfg1(r_q.cfg1),
    .cfg2(r_q.cfg2),
    .cfg3(r_q.cfg3),
    .boot_select(dec_boot),
    .watchdog_enable(dec_wdog),
    .bo_detect(dec_bo_det),
    .bo_level_low(dec_bo_lvl),
    .bo_reset(dec_bo_rst),
    .df_active(dec_df_act),
    .df_base(dec_df_base),
    .app_memory_present(dec_app_mem),
    .clock_filter_enable(dec_clk_filt),
    .rc_full_speed(dec_rc_full),
    .clk_src(dec_clk_src)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic wr_fire;
  logic rd_fire;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_ok;

  function automatic logic [7:0] cfg_merge(
    input logic [7:0] old,
    input logic [7:0] nv,
    input logic [7:0] keep
  );
    // reserved bits are forced to one, they can never be programmed
    cfg_merge = (nv & keep) | ~keep;
  endfunction

  always_comb
  begin
    r_d = r_q;
    wmask = {{8{r_q.w_strb[3]}}, {8{r_q.w_strb[2]}}, {8{r_q.w_strb[1]}}, {8{r_q.w_strb[0]}}};
    wval = r_q.w_data & wmask;
    wr_fire = r_q.aw_have && r_q.w_have && !r_q.bvalid;
    rd_fire = s_axi_arvalid && !r_q.rvalid;
    wr_ok = 1'b1;
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;

    // write channel capture, either order
    if (s_axi_awvalid && !r_q.aw_have)
    begin
      r_d.aw_have = 1'b1;
      r_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_q.w_have)
    begin
      r_d.w_have = 1'b1;
      r_d.w_data = s_axi_wdata;
      r_d.w_strb = s_axi_wstrb;
    end

    if (r_q.bvalid && s_axi_bready)
    begin
      r_d.bvalid = 1'b0;
    end
    if (r_q.rvalid && s_axi_rready)
    begin
      r_d.rvalid = 1'b0;
    end

    if (wr_fire)
    begin
      r_d.aw_have = 1'b0;
      r_d.w_have = 1'b0;
      r_d.bvalid = 1'b1;
      unique case (r_q.aw_addr)
        CBL_BOOT_FLASH_CFG_ADDR:
        begin
          if (r_q.w_strb[0])
          begin
            r_d.cfg0 = cfg_merge(r_q.cfg0, wval[7:0], CBL_CFG0_WMASK);
          end
        end
        CBL_FLASH_BASE_CFG_ADDR:
        begin
          if (r_q.w_strb[0])
          begin
            r_d.cfg1 = cfg_merge(r_q.cfg1, wval[7:0], CBL_CFG1_WMASK);
          end
        end
        CBL_BROWNOUT_CFG_ADDR:
        begin
          if (r_q.w_strb[0])
          begin
            r_d.cfg2 = cfg_merge(r_q.cfg2, wval[7:0], CBL_CFG2_WMASK);
          end
        end
        CBL_CLK_WDOG_CFG_ADDR:
        begin
          if (r_q.w_strb[0])
          begin
            r_d.cfg3 = cfg_merge(r_q.cfg3, wval[7:0], CBL_CFG3_WMASK);
          end
        end
        CBL_RUN_CTRL_ADDR:
        begin
          // software owns the run-time bits between resets
          if (r_q.w_strb[0])
          begin
            r_d.boot_sel = wval[CBL_RUN_BOOT_SEL_BIT];
            r_d.wdog_en = wval[CBL_RUN_WDOG_BIT];
            r_d.bo_det = wval[CBL_RUN_BO_DETECT_BIT];
            r_d.bo_lvl = wval[CBL_RUN_BO_LEVEL_BIT];
            r_d.bo_rst = wval[CBL_RUN_BO_RESET_BIT];
          end
          if (r_q.w_strb[1])
          begin
            r_d.df_base = wval[CBL_RUN_DF_BASE_LSB +: 8];
          end
        end
        CBL_RESET_CTRL_ADDR:
        begin
          if (r_q.w_strb[0] && r_q.st == CBL_ST_RUN)
          begin
            if (wval[CBL_RST_FULL_BIT])
            begin
              r_d.st = CBL_ST_HOLD_FULL;
              r_d.hold_cnt = CBL_RESET_HOLD_CYCLES;
            end
            else if (wval[CBL_RST_SOFT_BIT])
            begin
              r_d.st = CBL_ST_HOLD_SOFT;
              r_d.hold_cnt = CBL_RESET_HOLD_CYCLES;
            end
          end
        end
        default:
        begin
          wr_ok = 1'b0;
        end
      endcase
      r_d.bresp = wr_ok ? CBL_RESP_OKAY : CBL_RESP_SLVERR;
    end

    if (rd_fire)
    begin
      unique case (s_axi_araddr)
        CBL_BOOT_FLASH_CFG_ADDR: rd_val = {24'h00_0000, r_q.cfg0};
        CBL_FLASH_BASE_CFG_ADDR: rd_val = {24'h00_0000, r_q.cfg1};
        CBL_BROWNOUT_CFG_ADDR: rd_val = {24'h00_0000, r_q.cfg2};
        CBL_CLK_WDOG_CFG_ADDR: rd_val = {24'h00_0000, r_q.cfg3};
        CBL_RUN_CTRL_ADDR:
        begin
          rd_val = {16'h0000, r_q.df_base, 3'b000, r_q.bo_rst, r_q.bo_lvl, r_q.bo_det,
                    r_q.wdog_en, r_q.boot_sel};
        end
        CBL_RESET_CTRL_ADDR: rd_val = 32'h0000_0000;
        CBL_STATUS_ADDR:
        begin
          rd_val = {24'h00_0000, r_q.last_soft, r_q.app_mem, r_q.df_act, r_q.clk_filt,
                    r_q.rc_full, r_q.clk_src, (r_q.st != CBL_ST_RUN)};
        end
        default:
        begin
          rd_ok = 1'b0;
        end
      endcase
      r_d.rvalid = 1'b1;
      r_d.rdata = rd_val;
      r_d.rresp = rd_ok ? CBL_RESP_OKAY : CBL_RESP_SLVERR;
    end

    // ----------------------------------------------------------------
    // reset hold and field reload
    // ----------------------------------------------------------------
    unique case (r_q.st)
      CBL_ST_RUN:
      begin
      end
      CBL_ST_HOLD_FULL, CBL_ST_HOLD_SOFT:
      begin
        // fields reload every held cycle, so they are valid at release
        r_d.wdog_en = dec_wdog;
        r_d.bo_det = dec_bo_det;
        r_d.bo_lvl = dec_bo_lvl;
        r_d.bo_rst = dec_bo_rst;
        r_d.df_base = dec_df_base;
        r_d.df_act = dec_df_act;
        r_d.app_mem = dec_app_mem;
        r_d.clk_filt = dec_clk_filt;
        r_d.rc_full = dec_rc_full;
        r_d.clk_src = dec_clk_src;
        r_d.last_soft = (r_q.st == CBL_ST_HOLD_SOFT);
        if (r_q.st == CBL_ST_HOLD_FULL)
        begin
          r_d.boot_sel = dec_boot;
        end
        // soft reset leaves boot_sel as software last wrote it
        r_d.hold_cnt = r_q.hold_cnt - 4'h1;
        if (r_q.hold_cnt == 4'h1)
        begin
          r_d.st = CBL_ST_RUN;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_q <= '0;
      r_q.st <= CBL_ST_HOLD_FULL;
      r_q.hold_cnt <= CBL_RESET_HOLD_CYCLES;
      r_q.cfg0 <= CBL_UNPROGRAMMED;
      r_q.cfg1 <= CBL_UNPROGRAMMED;
      r_q.cfg2 <= CBL_UNPROGRAMMED;
      r_q.cfg3 <= CBL_UNPROGRAMMED;
      r_q.app_mem <= 1'b1;
      r_q.clk_src <= CBL_CLK_INTERNAL_RC;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign s_axi_awready = !r_q.aw_have;
  assign s_axi_wready = !r_q.w_have;
  assign s_axi_bvalid = r_q.bvalid;
  assign s_axi_bresp = r_q.bresp;
  assign s_axi_arready = !r_q.rvalid;
  assign s_axi_rvalid = r_q.rvalid;
  assign s_axi_rdata = r_q.rdata;
  assign s_axi_rresp = r_q.rresp;
  assign chip_reset_n = (r_q.st == CBL_ST_RUN);
  assign runtime_boot_select = r_q.boot_sel;
  assign watchdog_run_enable = r_q.wdog_en;
  assign brownout_detect_enable = r_q.bo_det;
  assign brownout_level_low = r_q.bo_lvl;
  assign brownout_reset_enable = r_q.bo_rst;
  assign data_flash_base_high = r_q.df_base;
  assign data_flash_active = r_q.df_act;
  assign application_memory_present = r_q.app_mem;
  assign clock_filter_enable = r_q.clk_filt;
  assign rc_frequency_select = r_q.rc_full;
  assign clock_source_sel = r_q.clk_src;

endmodule

/* File: rtl/cbl_pkg.sv */
// package: register map, field positions and reset values of the configuration byte loader
package cbl_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CBL_BOOT_FLASH_CFG_ADDR = 8'h00;
  localparam logic [7:0] CBL_FLASH_BASE_CFG_ADDR = 8'h04;
  localparam logic [7:0] CBL_BROWNOUT_CFG_ADDR = 8'h08;
  localparam logic [7:0] CBL_CLK_WDOG_CFG_ADDR = 8'h0C;
  localparam logic [7:0] CBL_RUN_CTRL_ADDR = 8'h10;
  localparam logic [7:0] CBL_RESET_CTRL_ADDR = 8'h14;
  localparam logic [7:0] CBL_STATUS_ADDR = 8'h18;

  // ----------------------------------------------------------------
  // configuration byte fields
  // ----------------------------------------------------------------
  localparam int CBL_BOOT_SOURCE_BIT = 7;
  localparam int CBL_DF_ENABLE_N_BIT = 0;
  localparam int CBL_BO_DETECT_BIT = 7;
  localparam int CBL_BO_LEVEL_BIT = 6;
  localparam int CBL_BO_RESET_BIT = 4;
  localparam int CBL_WDOG_N_BIT = 7;
  localparam int CBL_CLK_FILTER_BIT = 4;
  localparam int CBL_RC_FREQ_BIT = 3;
  localparam int CBL_CLK_SRC_HI_BIT = 1;
  localparam int CBL_CLK_SRC_LO_BIT = 0;

  // writable bits of each configuration byte; reserved bits stay unprogrammed
  localparam logic [7:0] CBL_CFG0_WMASK = 8'h83;
  localparam logic [7:0] CBL_CFG1_WMASK = 8'hFF;
  localparam logic [7:0] CBL_CFG2_WMASK = 8'hD0;
  localparam logic [7:0] CBL_CFG3_WMASK = 8'h9B;

  // ----------------------------------------------------------------
  // run-time control register fields (CBL_RUN_CTRL_ADDR)
  // ----------------------------------------------------------------
  localparam int CBL_RUN_BOOT_SEL_BIT = 0;
  localparam int CBL_RUN_WDOG_BIT = 1;
  localparam int CBL_RUN_BO_DETECT_BIT = 2;
  localparam int CBL_RUN_BO_LEVEL_BIT = 3;
  localparam int CBL_RUN_BO_RESET_BIT = 4;
  localparam int CBL_RUN_DF_BASE_LSB = 8;

  // reset control: bit 0 requests a software reset, bit 1 any other reset
  localparam int CBL_RST_SOFT_BIT = 0;
  localparam int CBL_RST_FULL_BIT = 1;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] CBL_UNPROGRAMMED = 8'hFF;
  localparam logic [7:0] CBL_DF_BASE_NONE = 8'h00;
  localparam logic [3:0] CBL_RESET_HOLD_CYCLES = 4'h4;

  localparam logic [1:0] CBL_RESP_OKAY = 2'b00;
  localparam logic [1:0] CBL_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CBL_CLK_CRYSTAL,
    CBL_CLK_EXT_INPUT,
    CBL_CLK_INTERNAL_RC
  } cbl_clk_src_t;

endpackage

/* File: rtl/cbl_field_decode.sv */
// combinational decode of configuration bytes into derived control fields
`timescale 1ns/10ps
module cbl_field_decode
  import cbl_pkg::*;
(
  input wire logic [7:0] cfg0,
  input wire logic [7:0] cfg1,
  input wire logic [7:0] cfg2,
  input wire logic [7:0] cfg3,
  output logic boot_select,
  output logic watchdog_enable,
  output logic bo_detect,
  output logic bo_level_low,
  output logic bo_reset,
  output logic df_active,
  output logic [7:0] df_base,
  output logic app_memory_present,
  output logic clock_filter_enable,
  output logic rc_full_speed,
  output cbl_clk_src_t clk_src
);

  always_comb
  begin
    // boot select is inverted: 1 means boot from loader memory
    boot_select = ~cfg0[CBL_BOOT_SOURCE_BIT];
    watchdog_enable = ~cfg3[CBL_WDOG_N_BIT];
    bo_detect = cfg2[CBL_BO_DETECT_BIT];
    bo_level_low = cfg2[CBL_BO_LEVEL_BIT];
    bo_reset = cfg2[CBL_BO_RESET_BIT];
    df_active = ~cfg0[CBL_DF_ENABLE_N_BIT];
    df_base = df_active ? cfg1 : CBL_DF_BASE_NONE;
    app_memory_present = !(df_active && (cfg1 == CBL_DF_BASE_NONE));
    clock_filter_enable = cfg3[CBL_CLK_FILTER_BIT];
    if (!cfg3[CBL_CLK_SRC_HI_BIT])
    begin
      clk_src = CBL_CLK_CRYSTAL;
    end
    else if (cfg3[CBL_CLK_SRC_LO_BIT])
    begin
      clk_src = CBL_CLK_INTERNAL_RC;
    end
    else
    begin
      clk_src = CBL_CLK_EXT_INPUT;
    end
    // divider bypass only matters for the internal oscillator
    rc_full_speed = (clk_src == CBL_CLK_INTERNAL_RC) && cfg3[CBL_RC_FREQ_BIT];
  end

endmodule

/* File: test/cbl_prog_model.sv */
// programmer model: AXI4-Lite master that writes and reads the configuration bytes
`timescale 1ns/10ps
module cbl_prog_model
(
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // cycles of delay before the response is accepted, to stall the slave
  int lag = 0;
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // released lines carry the inverse of the last value, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (n >= lag && !s_axi_bready)
        s_axi_bready <= 1'b1;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (n >= lag && !s_axi_rready)
        s_axi_rready <= 1'b1;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

/* File: test/cbl_loader_chk.sv */
// checker: bus handshakes and derived control outputs of the configuration byte loader
`timescale 1ns/10ps
module cbl_loader_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic chip_reset_n,
  input wire logic [7:0] data_flash_base_high,
  input wire logic data_flash_active,
  input wire logic application_memory_present,
  input wire logic rc_frequency_select,
  input wire logic [1:0] clock_source_sel
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // the load phase lasts four cycles whichever reset started it
  a_hold_release: assert property ($rose(aresetn) |-> !chip_reset_n[*4] ##1 chip_reset_n)
    else $error("chip reset not released after the load phase");
  a_hold_len: assert property ($fell(chip_reset_n) |-> !chip_reset_n[*4] ##1 chip_reset_n)
    else $error("requested reset hold has the wrong length");
  // software may rewrite the base later, so only the freshly loaded value is judged
  a_df_gate: assert property ($rose(chip_reset_n) && !data_flash_active
    |-> data_flash_base_high == 8'h00)
    else $error("data flash base shown while data flash disabled");
  a_rc_gate: assert property (rc_frequency_select |-> clock_source_sel == 2'h2)
    else $error("full rc speed without internal rc source");
  a_app_gone: assert property ($rose(chip_reset_n) && data_flash_active
    && data_flash_base_high == 8'h00 |-> !application_memory_present)
    else $error("application memory present with zero base");
  a_src_legal: assert property (clock_source_sel != 2'h3)
    else $error("illegal clock source code");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
endmodule
bind cbl_config_loader cbl_loader_chk i_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .chip_reset_n, .data_flash_base_high, .data_flash_active, .application_memory_present,
  .rc_frequency_select, .clock_source_sel);

/* File: test/tb.sv */
// testbench: programs the configuration bytes, issues resets and checks the loaded controls
`timescale 1ns/10ps
module tb;
  import cbl_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, data_flash_base_high;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, clock_source_sel, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, chip_reset_n;
  logic runtime_boot_select, watchdog_run_enable, brownout_detect_enable, brownout_level_low;
  logic brownout_reset_enable, data_flash_active, application_memory_present;
  logic clock_filter_enable, rc_frequency_select;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  wire [18:0] ctl = {runtime_boot_select, watchdog_run_enable, brownout_detect_enable,
    brownout_level_low, brownout_reset_enable, data_flash_active, application_memory_present,
    clock_filter_enable, rc_frequency_select, clock_source_sel, data_flash_base_high};
  always #12.5 aclk = ~aclk;
  cbl_config_loader i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_reset_n,
    .runtime_boot_select, .watchdog_run_enable, .brownout_detect_enable, .brownout_level_low,
    .brownout_reset_enable, .data_flash_base_high, .data_flash_active,
    .application_memory_present, .clock_filter_enable, .rc_frequency_select, .clock_source_sel);
  cbl_prog_model i_prog (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] eresp);
    i_prog.rd(a, rd, resp);
    chk("read data", exp, rd);
    chk("read response", {30'h0, eresp}, {30'h0, resp});
  endtask
  task automatic cfg_wr(input logic [7:0] a, input logic [7:0] v);
    i_prog.wr(a, {24'h0, v}, resp);
    chk("write response", {30'h0, CBL_RESP_OKAY}, {30'h0, resp});
  endtask
  // bounded waits: the hold must start and then end
  task automatic wait_run();
    for (int i = 0; i < 20 && chip_reset_n !== 1'b0; i++)
      @(posedge aclk);
    for (int i = 0; i < 20 && chip_reset_n !== 1'b1; i++)
    begin
      @(posedge aclk);
      #1;
    end
    chk("chip reset released", 32'h0000_0001, {31'h0, chip_reset_n});
  endtask
  task automatic do_reset(input logic full);
    cfg_wr(CBL_RESET_CTRL_ADDR, full ? 8'h02 : 8'h01);
    wait_run();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_unprog();
    wait_run();
    chk("controls", {9'h077, 2'h2, 8'h00},
      ctl);
    for (int i = 0; i < 4; i++)
      rd_chk(8'(4 * i), 32'h0000_00ff, CBL_RESP_OKAY);
    $display("unprogrammed bytes done");
  endtask
  task automatic t_clock();
    logic [7:0] v [5] = '{8'hff, 8'h66, 8'hfe, 8'hf4, 8'h77};
    logic [4:0] e [5] = '{5'h0e, 5'h11, 5'h09, 5'h08, 5'h1a};
    for (int i = 0; i < 5; i++)
    begin
      cfg_wr(CBL_CLK_WDOG_CFG_ADDR, v[i]);
      do_reset(1'b1);
      chk("clock controls", {27'h0, e[i]}, {watchdog_run_enable, clock_filter_enable,
        rc_frequency_select, clock_source_sel});
    end
    $display("clock modes done");
  endtask
  task automatic t_program();
    cfg_wr(CBL_BOOT_FLASH_CFG_ADDR, 8'h7e);
    cfg_wr(CBL_FLASH_BASE_CFG_ADDR, 8'h00);
    i_prog.lag = 3;
    cfg_wr(CBL_BROWNOUT_CFG_ADDR, 8'h2f);
    rd_chk(CBL_BROWNOUT_CFG_ADDR, 32'h0000_002f, CBL_RESP_OKAY);
    i_prog.lag = 0;
    do_reset(1'b1);
    chk("controls", {9'h18a, 2'h2, 8'h00}, ctl);
    $display("programmed bytes done");
  endtask
  task automatic t_soft();
    cfg_wr(CBL_RUN_CTRL_ADDR, 8'h00);
    @(posedge aclk);
    #1;
    chk("run control", 32'h0, {30'h0, runtime_boot_select, watchdog_run_enable});
    cfg_wr(CBL_FLASH_BASE_CFG_ADDR, 8'h12);
    do_reset(1'b0);
    chk("controls", {9'h08e, 2'h2, 8'h12}, ctl);
    rd_chk(CBL_RUN_CTRL_ADDR, 32'h0000_1202, CBL_RESP_OKAY);
    rd_chk(CBL_STATUS_ADDR, 32'h0000_00f4, CBL_RESP_OKAY);
    do_reset(1'b1);
    chk("controls", {9'h18e, 2'h2, 8'h12}, ctl);
    rd_chk(CBL_STATUS_ADDR, 32'h0000_0074, CBL_RESP_OKAY);
    $display("software reset done");
  endtask
  task automatic t_unmapped();
    i_prog.lag = 2;
    rd_chk(8'h1c, 32'h0, CBL_RESP_SLVERR);
    rd_chk(CBL_RESET_CTRL_ADDR, 32'h0, CBL_RESP_OKAY);
    i_prog.wr(8'h1c, 32'h0000_00ff, resp);
    chk("write response", {30'h0, CBL_RESP_SLVERR}, {30'h0, resp});
    i_prog.lag = 0;
    $display("unmapped access done");
  endtask
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_unprog();
    t_clock();
    t_program();
    t_soft();
    t_unmapped();
    end_of_test();
  end
endmodule
